// >>> rtl/ctlp_pkg.sv
// Shared constants, types and helpers of the calibration trigger and low-power control block
package ctlp_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_PIN_SETUP = 8'h6B;
	localparam logic [7:0] OFS_SOFT_TRIG = 8'h6C;
	localparam logic [7:0] OFS_LOW_POWER = 8'h6E;
	localparam logic [7:0] OFS_VEC_ACCESS = 8'h70;
	localparam logic [7:0] OFS_VEC_DATA = 8'h71;
	localparam logic [7:0] OFS_CAL_STATE = 8'h72;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h74;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h75;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_PIN_SETUP = 8'h00;
	localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
	localparam logic [7:0] RST_LOW_POWER = 8'h88;
	localparam logic [7:0] RST_VEC_ACCESS = 8'h00;
	localparam logic [7:0] RST_IRQ = 8'h00;

	// ****************************************
	// Field positions and codes
	// ****************************************
	localparam int POS_HW_SEL = 0;
	localparam int POS_STAT_SEL = 1;
	localparam int POS_SOFT_TRIG = 0;
	localparam int POS_LOWPOWER_CAL_ENABLE = 0;
	localparam int POS_TRIGGERED_SLEEP_MODE = 1;
	localparam int POS_WAKE = 3;
	localparam int POS_SLEEP = 5;
	localparam int POS_VEC_EN = 0;
	localparam logic [1:0] SEL_FOREGROUND_DONE = 2'h0;
	localparam logic [1:0] SEL_HALTED = 2'h1;
	localparam logic [1:0] SEL_ALARM = 2'h2;
	localparam logic [1:0] SEL_LOW = 2'h3;

	// ****************************************
	// Interrupt events
	// ****************************************
	localparam int IRQ_W = 4;
	localparam int EV_FOREGROUND_DONE = 0;
	localparam int EV_HALTED = 1;
	localparam int EV_VEC_DONE = 2;
	localparam int EV_VEC_REFUSED = 3;

	// ****************************************
	// Timing and sizes
	// ****************************************
	localparam int DLY_UNIT = 256;
	localparam int DLY_W = 42;
	localparam int EXP_MAX = 33;
	localparam int VEC_LEN = 673;
	localparam int IDX_W = 10;

	typedef enum logic [1:0] {LP_OFF, LP_SLEEP, LP_WAKE, LP_CAL} ctlp_lp_state_type;

	typedef struct packed {
		logic foreground_done;
		logic bg_halted;
		logic alarm;
	} ctlp_flags_type;

	typedef struct packed {
		logic [IDX_W-1:0] index;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} ctlp_vec_type;

	// Sleep code to exponent
	function automatic logic [5:0] sleep_exp(input logic [2:0] code);
		case (code)
			3'h0: sleep_exp = 6'h03;
			3'h1: sleep_exp = 6'h0F;
			3'h2: sleep_exp = 6'h12;
			3'h3: sleep_exp = 6'h15;
			3'h4: sleep_exp = 6'h18;
			3'h5: sleep_exp = 6'h1B;
			3'h6: sleep_exp = 6'h1E;
			default: sleep_exp = 6'h21;
		endcase
	endfunction

	// Wake code to exponent
	function automatic logic [5:0] wake_exp(input logic [1:0] code);
		case (code)
			2'h0: wake_exp = 6'h21;
			2'h1: wake_exp = 6'h12;
			2'h2: wake_exp = 6'h15;
			default: wake_exp = 6'h18;
		endcase
	endfunction
endpackage

// >>> rtl/ctlp_sync2.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/10ps
module ctlp_sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;

	// ****************************************
	// Synchroniser stages
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> rtl/ctlp_delay_timer.sv
// Down-counter that pulses once a loaded number of cycles has passed
`timescale 1ns/10ps
module ctlp_delay_timer #(
	parameter int W = 42
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic done
);
	logic [W-1:0] cnt_q;

	// ****************************************
	// Counter
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			done <= 1'b0;
		end else begin
			if (start) begin
				cnt_q <= load;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
			done <= !start && (cnt_q == {{(W-1){1'b0}}, 1'b1});
		end
	end

	timer_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		start |=> cnt_q == $past(load))
		else $error("timer did not load");
endmodule

// >>> rtl/ctlp_cal_trigger_lowpower_ctrl.sv
// Calibration trigger, status pin, low-power cycling and vector access control
//
// Functional notes
// - Status select routes done, halted, alarm, or low
// - Select zero: software bit drives trigger
// - Select one: trigger pin drives trigger
// - Writable software trigger bit resets to one
// - Sleep code sets (2^k+1)x256 sleep time
// - Wake code sets (2^k+1)x256 settle time
// - Triggered mode: wake only while trigger low
// - Autonomous mode: sleep time from code only
// - Low-power cycling needs enable and background
// - Vector port works only with access enabled
// - Full vector set takes 673 accesses
// - Foreground done flag feeds status pin
`timescale 1ns/10ps
module ctlp_cal_trigger_lowpower_ctrl
	import ctlp_pkg::*;
#(
	parameter int UNIT = DLY_UNIT,
	parameter int EXP_CAP = EXP_MAX,
	parameter int VLEN = VEC_LEN
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic cal_trigger_pin,
	output logic cal_status_pin,
	input wire ctlp_flags_type cal_flags,
	input wire logic background_cal_enable,
	input wire logic adc_cal_done,
	output logic cal_trigger,
	output logic adc_sleep,
	output logic adc_cal_start,
	input wire logic [7:0] vec_rdata,
	output logic [IDX_W-1:0] vec_cursor,
	output ctlp_vec_type vec_access,
	output logic irq
);
	logic [7:0] pin_setup_q;
	logic [7:0] soft_trig_q;
	logic [7:0] low_power_q;
	logic [7:0] vec_access_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] events;
	ctlp_flags_type flags_prev_q;
	ctlp_lp_state_type state_q;
	logic trig_sync;
	logic slp_start_q;
	logic wk_start_q;
	logic slp_done;
	logic wk_done;
	logic active;
	logic trig_mode;
	logic hw_trigger_select;
	logic vec_en;
	logic vec_hit;
	logic vec_last;
	logic [1:0] status_sel;

	// Delay in cycles for an exponent, capped for short simulations
	function automatic logic [DLY_W-1:0] dly_cycles(input logic [5:0] e);
		logic [5:0] ec;
		ec = (e > 6'(EXP_CAP)) ? 6'(EXP_CAP) : e;
		dly_cycles = ((DLY_W'(1) << ec) + DLY_W'(1)) * DLY_W'(UNIT);
	endfunction

	assign hw_trigger_select = pin_setup_q[POS_HW_SEL];
	assign status_sel = pin_setup_q[POS_STAT_SEL +: 2];
	assign trig_mode = low_power_q[POS_TRIGGERED_SLEEP_MODE];
	assign vec_en = vec_access_q[POS_VEC_EN];
	assign vec_hit = (addr == OFS_VEC_DATA) && (wr_en || rd_en);
	assign vec_last = vec_cursor == IDX_W'(VLEN - 1);

	// ****************************************
	// Pin synchroniser and delay timers
	// ****************************************
	ctlp_sync2 #(
		.RST_VAL(1'b1)
	) u_trig_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_in(cal_trigger_pin),
		.sync_out(trig_sync)
	);

	ctlp_delay_timer #(
		.W(DLY_W)
	) u_sleep_timer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.start(slp_start_q),
		.load(dly_cycles(sleep_exp(low_power_q[POS_SLEEP +: 3]))),
		.done(slp_done)
	);

	ctlp_delay_timer #(
		.W(DLY_W)
	) u_wake_timer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.start(wk_start_q),
		.load(dly_cycles(wake_exp(low_power_q[POS_WAKE +: 2]))),
		.done(wk_done)
	);

	// ****************************************
	// Configuration registers
	// ****************************************
	// pin setup, software trigger, low power, vector access and irq mask registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_setup_q <= RST_PIN_SETUP;
			soft_trig_q <= RST_SOFT_TRIG;
			low_power_q <= RST_LOW_POWER;
			vec_access_q <= RST_VEC_ACCESS;
			irq_mask_q <= IRQ_W'(RST_IRQ);
		end else if (wr_en) begin
			if (addr == OFS_PIN_SETUP) begin
				pin_setup_q <= wr_data;
			end else if (addr == OFS_SOFT_TRIG) begin
				soft_trig_q <= wr_data;
			end else if (addr == OFS_LOW_POWER) begin
				low_power_q <= wr_data;
			end else if (addr == OFS_VEC_ACCESS) begin
				vec_access_q <= wr_data;
			end else if (addr == OFS_IRQ_MASK) begin
				irq_mask_q <= wr_data[IRQ_W-1:0];
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			if (addr == OFS_PIN_SETUP) begin
				rd_data <= pin_setup_q;
			end else if (addr == OFS_SOFT_TRIG) begin
				rd_data <= soft_trig_q;
			end else if (addr == OFS_LOW_POWER) begin
				rd_data <= low_power_q;
			end else if (addr == OFS_VEC_ACCESS) begin
				rd_data <= vec_access_q;
			end else if (addr == OFS_VEC_DATA) begin
				rd_data <= vec_en ? vec_rdata : 8'h00;
			end else if (addr == OFS_CAL_STATE) begin
				rd_data <= {2'h0, state_q, adc_sleep, cal_flags};
			end else if (addr == OFS_IRQ_STATUS) begin
				rd_data <= 8'(irq_status_q);
			end else if (addr == OFS_IRQ_MASK) begin
				rd_data <= 8'(irq_mask_q);
			end else begin
				rd_data <= 8'h00;
			end
		end else begin
			rd_data <= 8'h00;
		end
	end

	// ****************************************
	// Trigger source and status pin
	// ****************************************
	// registered select, no glitches
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cal_trigger <= 1'b1;
			cal_status_pin <= 1'b0;
		end else begin
			// software bit when select is zero
			cal_trigger <= hw_trigger_select ? trig_sync : soft_trig_q[POS_SOFT_TRIG];
			case (status_sel)
				SEL_FOREGROUND_DONE: cal_status_pin <= cal_flags.foreground_done;
				SEL_HALTED: cal_status_pin <= cal_flags.bg_halted;
				SEL_ALARM: cal_status_pin <= cal_flags.alarm;
				default: cal_status_pin <= 1'b0;
			endcase
		end
	end

	// ****************************************
	// Low-power sleep and wake cycling
	// ****************************************
	// both enables needed
	assign active = low_power_q[POS_LOWPOWER_CAL_ENABLE] && background_cal_enable;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= LP_OFF;
			slp_start_q <= 1'b0;
			wk_start_q <= 1'b0;
			adc_cal_start <= 1'b0;
		end else begin
			slp_start_q <= 1'b0;
			wk_start_q <= 1'b0;
			adc_cal_start <= 1'b0;
			case (state_q)
				LP_OFF: begin
					if (active) begin
						state_q <= LP_SLEEP;
						slp_start_q <= !trig_mode;
					end
				end
				LP_SLEEP: begin
					if (!active) begin
						state_q <= LP_OFF;
					end else if (trig_mode ? !cal_trigger : slp_done) begin
						state_q <= LP_WAKE;
						wk_start_q <= 1'b1;
					end
				end
				LP_WAKE: begin
					if (!active) begin
						state_q <= LP_OFF;
					end else if (wk_done) begin
						state_q <= LP_CAL;
						adc_cal_start <= 1'b1;
					end
				end
				default: begin
					if (!active) begin
						state_q <= LP_OFF;
					end else if (adc_cal_done) begin
						state_q <= LP_SLEEP;
						slp_start_q <= !trig_mode;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			adc_sleep <= 1'b0;
		end else begin
			adc_sleep <= state_q == LP_SLEEP;
		end
	end

	// ****************************************
	// Calibration vector port
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			vec_cursor <= '0;
			vec_access <= '0;
		end else begin
			vec_access.wr <= 1'b0;
			vec_access.rd <= 1'b0;
			if (!vec_en) begin
				vec_cursor <= '0;
			end else if (vec_hit) begin
				vec_access.index <= vec_cursor;
				vec_access.wr <= wr_en;
				vec_access.rd <= rd_en;
				vec_access.wdata <= wr_data;
				vec_cursor <= vec_last ? '0 : vec_cursor + 1'b1;
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_comb begin
		events = '0;
		events[EV_FOREGROUND_DONE] = cal_flags.foreground_done && !flags_prev_q.foreground_done;
		events[EV_HALTED] = cal_flags.bg_halted && !flags_prev_q.bg_halted;
		events[EV_VEC_DONE] = vec_en && vec_hit && vec_last;
		events[EV_VEC_REFUSED] = !vec_en && vec_hit;
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_prev_q <= '0;
			irq_status_q <= '0;
			irq <= 1'b0;
		end else begin
			flags_prev_q <= cal_flags;
			if (wr_en && addr == OFS_IRQ_STATUS) begin
				irq_status_q <= (irq_status_q & ~wr_data[IRQ_W-1:0]) | events;
			end else begin
				irq_status_q <= irq_status_q | events;
			end
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence vec_final_s;
		vec_en && vec_hit && vec_last;
	endsequence

	status_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		status_sel == SEL_LOW |=> !cal_status_pin)
		else $error("status pin not low");
	status_done_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		status_sel == SEL_FOREGROUND_DONE |=> cal_status_pin == $past(cal_flags.foreground_done))
		else $error("status pin not done flag");
	status_alarm_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		status_sel == SEL_ALARM |=> cal_status_pin == $past(cal_flags.alarm))
		else $error("status pin not alarm");
	soft_source_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!hw_trigger_select |=> cal_trigger == $past(soft_trig_q[POS_SOFT_TRIG]))
		else $error("trigger not from software bit");
	pin_source_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		hw_trigger_select |=> cal_trigger == $past(trig_sync))
		else $error("trigger not from pin");
	soft_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_en && addr == OFS_SOFT_TRIG |=> soft_trig_q == $past(wr_data))
		else $error("software trigger not written");
	trig_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_q == LP_SLEEP && active && trig_mode && cal_trigger |=> state_q == LP_SLEEP)
		else $error("woke without low trigger");
	auto_sleep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_q == LP_SLEEP && active && !trig_mode && !slp_done |=> state_q == LP_SLEEP)
		else $error("woke before sleep timer");
	settle_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state_q == LP_WAKE && active && wk_done |=> state_q == LP_CAL && adc_cal_start)
		else $error("calibration not started after settle");
	lp_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!active |=> state_q == LP_OFF)
		else $error("cycling without enables");
	vec_block_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!vec_en |=> !vec_access.wr && !vec_access.rd && vec_cursor == '0)
		else $error("vector access while disabled");
	vec_wrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		vec_final_s |=> vec_cursor == '0 ##0 irq_status_q[EV_VEC_DONE])
		else $error("vector set not closed at last access");
endmodule

// >>> sim/ctlp_host_model.sv
// Partner model: trigger pin driver, calibration engine and vector store
`timescale 1ns/10ps
module ctlp_host_model
	import ctlp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic pin_level,
	output logic cal_trigger_pin,
	input wire logic adc_cal_start,
	output logic adc_cal_done,
	input wire logic [IDX_W-1:0] vec_cursor,
	input wire ctlp_vec_type vec_access,
	output logic [7:0] vec_rdata
);
	logic [7:0] store_q [0:(1<<IDX_W)-1];
	logic [3:0] busy_q;
	logic slow_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cal_trigger_pin <= 1'b1;
		end else begin
			cal_trigger_pin <= pin_level;
		end
	end

	// Engine answers promptly and slowly in turn
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 4'h0;
			slow_q <= 1'b0;
			adc_cal_done <= 1'b0;
		end else begin
			adc_cal_done <= (busy_q == 4'h1);
			if (adc_cal_start) begin
				busy_q <= slow_q ? 4'h9 : 4'h2;
				slow_q <= ~slow_q;
			end else if (busy_q != 4'h0) begin
				busy_q <= busy_q - 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (vec_access.wr) begin
			store_q[vec_access.index] <= vec_access.wdata;
		end
	end
	assign vec_rdata = store_q[vec_cursor];
endmodule

// >>> sim/ctlp_cal_trigger_lowpower_ctrl_tb.sv
// Self-checking testbench of the calibration trigger and low-power control block
`timescale 1ns/10ps
module ctlp_cal_trigger_lowpower_ctrl_tb;
	import ctlp_pkg::*;
	localparam int UN = 2;
	localparam int CAP = 4;
	localparam int VL = 8;
	logic ref_clk;
	logic arst_n;
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [7:0] rd_data;
	logic pin_level;
	logic cal_trigger_pin;
	logic cal_status_pin;
	ctlp_flags_type cal_flags;
	logic background_cal_enable;
	logic adc_cal_done;
	logic cal_trigger;
	logic adc_sleep;
	logic adc_cal_start;
	logic [7:0] vec_rdata;
	logic [IDX_W-1:0] vec_cursor;
	ctlp_vec_type vec_access;
	logic irq;
	int error_cnt;
	int num_checks;
	int seed;
	int n;
	logic [31:0] r;
	logic [7:0] data [0:VL-1];
	logic [IDX_W-1:0] idx_q [$];

	ctlp_cal_trigger_lowpower_ctrl #(.UNIT(UN), .EXP_CAP(CAP), .VLEN(VL)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.cal_trigger_pin(cal_trigger_pin), .cal_status_pin(cal_status_pin), .cal_flags(cal_flags),
		.background_cal_enable(background_cal_enable), .adc_cal_done(adc_cal_done), .cal_trigger(cal_trigger),
		.adc_sleep(adc_sleep), .adc_cal_start(adc_cal_start), .vec_rdata(vec_rdata), .vec_cursor(vec_cursor),
		.vec_access(vec_access), .irq(irq));

	ctlp_host_model host (.ref_clk(ref_clk), .arst_n(arst_n), .pin_level(pin_level),
		.cal_trigger_pin(cal_trigger_pin), .adc_cal_start(adc_cal_start), .adc_cal_done(adc_cal_done),
		.vec_cursor(vec_cursor), .vec_access(vec_access), .vec_rdata(vec_rdata));

	// ****
	// Helpers
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (vec_access.wr === 1'b1 || vec_access.rd === 1'b1) begin
			idx_q.push_back(vec_access.index);
		end
	end

	function automatic int dly(input int e);
		dly = ((1 << ((e < CAP) ? e : CAP)) + 1) * UN;
	endfunction

	function automatic logic stat_exp(input logic [1:0] c, input ctlp_flags_type f);
		case (c)
			2'h0: stat_exp = f.foreground_done;
			2'h1: stat_exp = f.bg_halted;
			2'h2: stat_exp = f.alarm;
			default: stat_exp = 1'b0;
		endcase
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			error_cnt++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data === e, "read data");
	endtask

	task automatic wait_for(input bit sel, input logic lvl, output int cnt);
		cnt = 0;
		while (((sel ? adc_cal_start : adc_sleep) !== lvl) && cnt < 400) begin
			tick(1);
			cnt++;
		end
		chk(cnt < 400, "wait limit");
	endtask

	task automatic chk_idx(input string m);
		bit ok;
		ok = (idx_q.size() == VL);
		for (int i = 0; i < idx_q.size(); i++) begin
			if (idx_q[i] !== i[IDX_W-1:0]) ok = 1'b0;
		end
		idx_q.delete();
		chk(ok, m);
	endtask

	task automatic final_report();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end

	// ****
	// Scenarios
	// ****
	initial begin
		seed = 32'h4C0C195F;
		error_cnt = 0;
		num_checks = 0;
		arst_n = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		pin_level = 1'b1;
		cal_flags = 3'h0;
		background_cal_enable = 1'b0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		tick(1);
		chk(cal_trigger === 1'b1 && adc_sleep === 1'b0, "reset outputs");
		rdc(OFS_PIN_SETUP, 8'h00);
		rdc(OFS_SOFT_TRIG, 8'h01);
		rdc(OFS_LOW_POWER, 8'h88);
		rdc(OFS_VEC_ACCESS, 8'h00);
		rdc(8'h6D, 8'h00);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			@(posedge ref_clk);
			cal_flags <= r[2:0];
			wr(OFS_PIN_SETUP, {5'h00, i[1:0], 1'b0});
			tick(3);
			chk(cal_status_pin === stat_exp(i[1:0], cal_flags), "status pin");
		end
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			wr(OFS_PIN_SETUP, {7'h00, r[0]});
			wr(OFS_SOFT_TRIG, r[15:8]);
			pin_level <= r[1];
			tick(5);
			chk(cal_trigger === (r[0] ? r[1] : r[8]), "trigger source");
		end
		wr(OFS_PIN_SETUP, 8'h00);
		wr(OFS_SOFT_TRIG, 8'h01);
		pin_level <= 1'b1;
		cal_flags <= 3'b010;
		tick(3);
		wr(OFS_IRQ_STATUS, 8'hFF);
		wr(OFS_IRQ_MASK, 8'h08);
		wr(OFS_VEC_DATA, 8'h5A);
		rdc(OFS_VEC_DATA, 8'h00);
		tick(2);
		chk(irq === 1'b1 && idx_q.size() == 0, "refused access");
		wr(OFS_IRQ_STATUS, 8'h08);
		tick(2);
		chk(irq === 1'b0, "irq clear");
		rdc(OFS_IRQ_STATUS, 8'h00);
		wr(OFS_VEC_ACCESS, 8'h01);
		for (int i = 0; i < VL; i++) begin
			r = $random(seed);
			data[i] = r[7:0];
			wr(OFS_VEC_DATA, r[7:0]);
		end
		tick(2);
		chk_idx("vector write order");
		rdc(OFS_IRQ_STATUS, 8'h04);
		wr(OFS_IRQ_MASK, 8'h04);
		tick(2);
		chk(irq === 1'b1, "set done irq");
		for (int i = 0; i < VL; i++) begin
			rdc(OFS_VEC_DATA, data[i]);
		end
		tick(2);
		chk_idx("vector read order");
		wr(OFS_IRQ_MASK, 8'h00);
		tick(2);
		chk(irq === 1'b0, "masked irq");
		wr(OFS_VEC_ACCESS, 8'h00);
		@(posedge ref_clk);
		background_cal_enable <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			wr(OFS_LOW_POWER, 8'h00);
			wr(OFS_LOW_POWER, {c[2:0], c[1:0], 3'b001});
			wait_for(1'b0, 1'b1, n);
			wait_for(1'b0, 1'b0, n);
			r = dly((c == 0) ? 3 : 12 + 3 * c);
			chk(n >= r - 1 && n <= r + 4, "sleep time");
			wait_for(1'b1, 1'b1, n);
			r = dly((c % 4 == 0) ? 33 : 15 + 3 * (c % 4));
			chk(n >= r - 2 && n <= r + 4, "wake time");
		end
		@(posedge ref_clk);
		background_cal_enable <= 1'b0;
		tick(3);
		n = 0;
		repeat (60) begin
			tick(1);
			if (adc_sleep !== 1'b0) n++;
		end
		chk(n == 0, "cycling without background");
		@(posedge ref_clk);
		background_cal_enable <= 1'b1;
		wr(OFS_LOW_POWER, 8'h8B);
		wait_for(1'b0, 1'b1, n);
		tick(60);
		chk(adc_sleep === 1'b1, "triggered sleep held");
		rdc(OFS_CAL_STATE, 8'h1A);
		wr(OFS_SOFT_TRIG, 8'h00);
		wait_for(1'b0, 1'b0, n);
		chk(n <= 6, "wake on low trigger");
		wr(OFS_SOFT_TRIG, 8'h01);
		tick(2);
		@(posedge ref_clk);
		arst_n <= 1'b0;
		cal_flags <= 3'h0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		tick(1);
		chk(cal_trigger === 1'b1 && adc_sleep === 1'b0 && irq === 1'b0, "mid-run reset outputs");
		rdc(OFS_LOW_POWER, 8'h88);
		rdc(OFS_IRQ_STATUS, 8'h00);
		final_report();
	end
endmodule
